// ==== aps_defines.svh ====
// Purpose: Register offsets, field positions, reset values and code tables
//          for the audio serial port slot and master clock configuration.
// Assumes: Eight-bit control registers on the documented control port.
// Notes:   Definitions only; included by bare name.
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH

// ==========================================================================
// Register offsets
`define APS_OFS_CH7        8'h11
`define APS_OFS_CH8        8'h12
`define APS_OFS_MCFG       8'h13

// ==========================================================================
// Reset values
`define APS_RST_CH7        8'h06
`define APS_RST_CH8        8'h07
`define APS_RST_MCFG       8'h02

// ==========================================================================
// Field positions
`define APS_SLOT_MSB       5
`define APS_HALF_BIT       5
`define APS_LINE_BIT       6
`define APS_ROLE_BIT       7
`define APS_AUTO_BIT       6
`define APS_PLLBYP_BIT     5
`define APS_GATE_BIT       4
`define APS_FAM_BIT        3
`define APS_FREQ_MSB       2

// ==========================================================================
// Writable mask of a channel slot register; bit 7 is reserved.
`define APS_CH_WMASK       8'h7F

// ==========================================================================
// Reference clock frequency per code, in kHz.
`define APS_REF_KHZ_0      16'd12000
`define APS_REF_KHZ_1      16'd12288
`define APS_REF_KHZ_2      16'd13000
`define APS_REF_KHZ_3      16'd16000
`define APS_REF_KHZ_4      16'd19200
`define APS_REF_KHZ_5      16'd19680
`define APS_REF_KHZ_6      16'd24000
`define APS_REF_KHZ_7      16'd24576

// Base sample rates of the two families, in Hz.
`define APS_BASE_HZ_48K    17'd48000
`define APS_BASE_HZ_44K1   17'd44100

`endif

// ==== aps_pkg.sv ====
// Purpose: Types shared by the audio serial port configuration block.
// Assumes: Used only through scoped names.
// Notes:   Offsets and figures live in aps_defines.svh.
package aps_pkg;

  // ========================================================================
  // Framing format of the serial port.
  typedef enum logic [1:0]
  {
    APS_FMT_TDM = 2'b00,
    APS_FMT_I2S = 2'b01,
    APS_FMT_LJ  = 2'b10
  } aps_fmt_t;

endpackage : aps_pkg

// ==== aps_slot_clk_cfg.sv ====
// Purpose: Slot map of channels 7 and 8 and the master clock controls of
//          the audio serial port, with the decoded settings they steer.
// Assumes: Register port and all inputs synchronous to CLK.
// Notes:   Decoded outputs follow a register write after two edges.
`timescale 1ns/1ns
`include "aps_defines.svh"

module aps_slot_clk_cfg
(
  input  wire logic            CLK,
  input  wire logic            SRST,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic            REG_WE,
  input  wire logic [7:0]      REG_WDATA,
  output logic      [7:0]      REG_RDATA,
  input  wire aps_pkg::aps_fmt_t FRAME_FORMAT,
  input  wire logic            REF_SELECT_MODE,
  input  wire logic            BCLK_GEN,
  input  wire logic            FRAME_SYNC_GEN,
  output logic      [5:0]      CHAN7_SLOT,
  output logic                 CHAN7_RIGHT,
  output logic                 CHAN7_LINE_SELECT,
  output logic      [5:0]      CHAN8_SLOT,
  output logic                 CHAN8_RIGHT,
  output logic                 CHAN8_LINE_SELECT,
  output logic                 PORT_IS_MASTER,
  output logic                 AUTO_DERIVE_EN,
  output logic                 PLL_EN,
  output logic                 BCLK_OUT,
  output logic                 BCLK_OE,
  output logic                 FRAME_SYNC_OUT,
  output logic                 FRAME_SYNC_OE,
  output logic      [16:0]     BASE_RATE_HZ,
  output logic      [15:0]     REF_FREQ_KHZ,
  output logic                 REF_CODE_VALID,
  output logic                 REF_FROM_FRAME_SYNC
);

  // ========================================================================
  // Registers
  logic [7:0]  ch7_r,  ch7_nxt;
  logic [7:0]  ch8_r,  ch8_nxt;
  logic [7:0]  mcfg_r, mcfg_nxt;
  logic        wr7, wr8, wrm;

  // Writes land on a matching offset; reserved bit 7 is masked away.
  always_comb
  begin
    wr7      = REG_WE && (REG_ADDR == `APS_OFS_CH7);
    wr8      = REG_WE && (REG_ADDR == `APS_OFS_CH8);
    wrm      = REG_WE && (REG_ADDR == `APS_OFS_MCFG);
    ch7_nxt  = wr7 ? (REG_WDATA & `APS_CH_WMASK) : ch7_r;
    ch8_nxt  = wr8 ? (REG_WDATA & `APS_CH_WMASK) : ch8_r;
    mcfg_nxt = wrm ? REG_WDATA : mcfg_r;
  end

  // Reset values put channel 7 at slot 6 and 8 at slot 7 on the primary line.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ch7_r  <= `APS_RST_CH7;
      ch8_r  <= `APS_RST_CH8;
      mcfg_r <= `APS_RST_MCFG;
    end
    else
    begin
      ch7_r  <= ch7_nxt;
      ch8_r  <= ch8_nxt;
      mcfg_r <= mcfg_nxt;
    end
  end

  // Read data is combinational; unmapped offsets read as zero.
  always_comb
  begin
    unique case (REG_ADDR)
      `APS_OFS_CH7:  REG_RDATA = ch7_r;
      `APS_OFS_CH8:  REG_RDATA = ch8_r;
      `APS_OFS_MCFG: REG_RDATA = mcfg_r;
      default:       REG_RDATA = 8'h00;
    endcase
  end

  // ========================================================================
  // Decode
  logic        master;
  logic        tdm;
  logic [15:0] ref_khz;
  logic [5:0]  s7_nxt, s8_nxt;
  logic        r7_nxt, r8_nxt;
  logic        bclk_nxt, frame_sync_nxt, gated;

  // Reference table lookup; the code index is always legal.
  function automatic logic [15:0] ref_lookup(input logic [2:0] code);
    unique case (code)
      3'h0: ref_lookup = `APS_REF_KHZ_0;
      3'h1: ref_lookup = `APS_REF_KHZ_1;
      3'h2: ref_lookup = `APS_REF_KHZ_2;
      3'h3: ref_lookup = `APS_REF_KHZ_3;
      3'h4: ref_lookup = `APS_REF_KHZ_4;
      3'h5: ref_lookup = `APS_REF_KHZ_5;
      3'h6: ref_lookup = `APS_REF_KHZ_6;
      3'h7: ref_lookup = `APS_REF_KHZ_7;
    endcase
  endfunction : ref_lookup

  // In TDM the full code is the slot; in two-half framing bit 5 picks the
  // half and the lower five bits pick the slot within it.
  always_comb
  begin
    master  = mcfg_r[`APS_ROLE_BIT];
    tdm     = (FRAME_FORMAT == aps_pkg::APS_FMT_TDM);
    ref_khz = ref_lookup(mcfg_r[`APS_FREQ_MSB:0]);
    s7_nxt  = tdm ? ch7_r[`APS_SLOT_MSB:0] :
              {1'b0, ch7_r[`APS_SLOT_MSB-1:0]};
    s8_nxt  = tdm ? ch8_r[`APS_SLOT_MSB:0] :
              {1'b0, ch8_r[`APS_SLOT_MSB-1:0]};
    r7_nxt  = !tdm && ch7_r[`APS_HALF_BIT];
    r8_nxt  = !tdm && ch8_r[`APS_HALF_BIT];
    // Gating only counts when driving; as slave the pins are not ours.
    gated     = master && mcfg_r[`APS_GATE_BIT];
    bclk_nxt  = master && !gated && BCLK_GEN;
    frame_sync_nxt = master && !gated && FRAME_SYNC_GEN;
  end

  // Decoded settings are registered so every decoded output comes from a flop.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      CHAN7_SLOT        <= 6'h00;
      CHAN7_RIGHT       <= 1'b0;
      CHAN7_LINE_SELECT <= 1'b0;
      CHAN8_SLOT        <= 6'h00;
      CHAN8_RIGHT       <= 1'b0;
      CHAN8_LINE_SELECT <= 1'b0;
      PORT_IS_MASTER    <= 1'b0;
      AUTO_DERIVE_EN    <= 1'b0;
      PLL_EN            <= 1'b0;
      BCLK_OUT          <= 1'b0;
      BCLK_OE           <= 1'b0;
      FRAME_SYNC_OUT         <= 1'b0;
      FRAME_SYNC_OE          <= 1'b0;
      BASE_RATE_HZ      <= 17'h00000;
      REF_FREQ_KHZ      <= 16'h0000;
      REF_CODE_VALID    <= 1'b0;
      REF_FROM_FRAME_SYNC    <= 1'b0;
    end
    else
    begin
      CHAN7_SLOT        <= s7_nxt;
      CHAN7_RIGHT       <= r7_nxt;
      CHAN7_LINE_SELECT <= ch7_r[`APS_LINE_BIT];
      CHAN8_SLOT        <= s8_nxt;
      CHAN8_RIGHT       <= r8_nxt;
      CHAN8_LINE_SELECT <= ch8_r[`APS_LINE_BIT];
      PORT_IS_MASTER    <= master;
      BCLK_OE           <= master;
      FRAME_SYNC_OE          <= master;
      BCLK_OUT          <= bclk_nxt;
      FRAME_SYNC_OUT         <= frame_sync_nxt;
      AUTO_DERIVE_EN    <= !mcfg_r[`APS_AUTO_BIT];
      // Outside automatic clocking the PLL is held off; inside it bit 5 bypasses it.
      PLL_EN            <= !mcfg_r[`APS_AUTO_BIT] &&
                           !mcfg_r[`APS_PLLBYP_BIT];
      BASE_RATE_HZ      <= !master ? 17'h00000 :
                           (mcfg_r[`APS_FAM_BIT] ? `APS_BASE_HZ_44K1 :
                                                   `APS_BASE_HZ_48K);
      REF_CODE_VALID    <= master && !REF_SELECT_MODE;
      REF_FREQ_KHZ      <= (master && !REF_SELECT_MODE) ? ref_khz :
                           16'h0000;
      REF_FROM_FRAME_SYNC    <= master && REF_SELECT_MODE;
    end
  end

  // ========================================================================
  // Checks
  a_slot_tdm_map: assert property (@(posedge CLK) disable iff (SRST)
    tdm |=> CHAN7_SLOT == $past(ch7_r[`APS_SLOT_MSB:0]))
    else $error("channel 7 TDM slot does not match its code");

  a_half_frame_map: assert property (@(posedge CLK) disable iff (SRST)
    !tdm |=>
    CHAN8_RIGHT == $past(ch8_r[`APS_HALF_BIT]) && !CHAN8_SLOT[`APS_SLOT_MSB])
    else $error("channel 8 half frame decode wrong");

  a_line_select: assert property (@(posedge CLK) disable iff (SRST)
    wr7 ##1 !wr7 |=>
    CHAN7_LINE_SELECT == $past(REG_WDATA[`APS_LINE_BIT], 2))
    else $error("channel 7 line select did not follow write");

  a_reset_slots: assert property (@(posedge CLK)
    $past(SRST) |-> ch7_r == `APS_RST_CH7 && ch8_r == `APS_RST_CH8)
    else $error("slot registers not at reset values");

  a_role_drive: assert property (@(posedge CLK) disable iff (SRST)
    (BCLK_OE == FRAME_SYNC_OE) && (BCLK_OE || (!BCLK_OUT && !FRAME_SYNC_OUT)))
    else $error("pin enables disagree or idle pins toggling");

  a_auto_derive: assert property (@(posedge CLK) disable iff (SRST)
    wrm ##1 !wrm |=>
    AUTO_DERIVE_EN == !$past(REG_WDATA[`APS_AUTO_BIT], 2))
    else $error("auto derive enable wrong");

  a_pll_bypass: assert property (@(posedge CLK) disable iff (SRST)
    PLL_EN == (AUTO_DERIVE_EN && !$past(mcfg_r[`APS_PLLBYP_BIT])))
    else $error("PLL enabled outside automatic clocking");

  a_clock_gate: assert property (@(posedge CLK) disable iff (SRST)
    gated |=> !BCLK_OUT && !FRAME_SYNC_OUT)
    else $error("gated clocks still toggling");

  a_rate_family: assert property (@(posedge CLK) disable iff (SRST)
    master && mcfg_r[`APS_FAM_BIT] |=> BASE_RATE_HZ == `APS_BASE_HZ_44K1)
    else $error("44.1 kHz family not selected");

  a_ref_code_use: assert property (@(posedge CLK) disable iff (SRST)
    !REF_CODE_VALID |-> REF_FREQ_KHZ == 16'h0000)
    else $error("reference code used while invalid");

  a_ref_frame_sync: assert property (@(posedge CLK) disable iff (SRST)
    !(REF_FROM_FRAME_SYNC && REF_CODE_VALID))
    else $error("both reference sources active");

  a_reserved_zero: assert property (@(posedge CLK) disable iff (SRST)
    !ch7_r[7] && !ch8_r[7])
    else $error("reserved slot bit set");

endmodule : aps_slot_clk_cfg

// ==== aps_host_model.sv ====
// Purpose: Far-end host of the serial port, sharing bit clock and frame sync.
// Assumes: Runs on the bench clock; releases the lines while the port drives.
// Notes:   Resolves each shared line from the port's enable alone.
`timescale 1ns/1ns

// ==========================================================================
// Host model
module aps_host_model
(
  input  wire logic CLK,
  input  wire logic BCLK_OE,
  input  wire logic BCLK_OUT,
  input  wire logic FRAME_SYNC_OE,
  input  wire logic FRAME_SYNC_OUT,
  output logic      BCLK_LINE,
  output logic      FRAME_SYNC_LINE
);
  logic       host_bclk_r = 1'b0;
  logic [3:0] div_r       = 4'h0;

  // The host clocks a slave port itself; a short frame keeps runs brief.
  always_ff @(posedge CLK)
  begin
    host_bclk_r <= ~host_bclk_r;
    div_r       <= div_r + 4'h1;
  end

  // Whoever enables drives; the host backs off while the port is master.
  assign BCLK_LINE  = BCLK_OE ? BCLK_OUT : host_bclk_r;
  assign FRAME_SYNC_LINE = FRAME_SYNC_OE ? FRAME_SYNC_OUT : (div_r == 4'h0);
endmodule : aps_host_model

// ==== aps_slot_clk_cfg_tb.sv ====
// Purpose: Self-checking bench of the slot map and master clock controls.
// Assumes: Inputs change on the falling edge; outputs settle by then.
// Notes:   Decoded outputs are checked two edges after the register edge.
`timescale 1ns/1ns
`include "aps_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); \
  end end

// ==========================================================================
// Bench top
module aps_slot_clk_cfg_tb;
  logic clk, srst, we, refsel, gen_b, gen_f, c7l, c7r, c8l, c8r, master;
  logic auto_en, pll_en, bo, boe, fo, foe, ref_ok, ref_fs, bl, fl, prev;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] c7s, c8s;
  logic [16:0] base_hz;
  logic [15:0] ref_khz;
  aps_pkg::aps_fmt_t fmt;
  int miscompares = 0;
  int check_count = 0;
  logic [15:0] ref_tab [8] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80,
                               16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};

  aps_slot_clk_cfg dut (.CLK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_WE(we), .REG_WDATA(wdata), .REG_RDATA(rdata), .FRAME_FORMAT(fmt),
    .REF_SELECT_MODE(refsel), .BCLK_GEN(gen_b), .FRAME_SYNC_GEN(gen_f),
    .CHAN7_SLOT(c7s), .CHAN7_RIGHT(c7r), .CHAN7_LINE_SELECT(c7l),
    .CHAN8_SLOT(c8s), .CHAN8_RIGHT(c8r), .CHAN8_LINE_SELECT(c8l),
    .PORT_IS_MASTER(master), .AUTO_DERIVE_EN(auto_en), .PLL_EN(pll_en),
    .BCLK_OUT(bo), .BCLK_OE(boe), .FRAME_SYNC_OUT(fo), .FRAME_SYNC_OE(foe),
    .BASE_RATE_HZ(base_hz), .REF_FREQ_KHZ(ref_khz),
    .REF_CODE_VALID(ref_ok), .REF_FROM_FRAME_SYNC(ref_fs));

  aps_host_model host (.CLK(clk), .BCLK_OE(boe), .BCLK_OUT(bo),
    .FRAME_SYNC_OE(foe), .FRAME_SYNC_OUT(fo), .BCLK_LINE(bl), .FRAME_SYNC_LINE(fl));

  // A free clock; every stimulus change waits for a falling edge.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step;
    @(negedge clk);
  endtask : step

  // One write strobe of one cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    step;
    we = 1'b0;
    step;
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    #1;
    `CHK(rdata, e)
    step;
  endtask : chk_rd

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic t_reset;
    chk_rd(`APS_OFS_CH7, 8'h06);
    chk_rd(`APS_OFS_CH8, 8'h07);
    chk_rd(`APS_OFS_MCFG, 8'h02);
    chk_rd(8'h14, 8'h00);
    `CHK({c7l, c7s, c8l, c8s}, 14'h0307)
    `CHK({auto_en, pll_en, master, boe}, 4'hC)
    $display("test reset done");
  endtask : t_reset

  // Slot codes at 63 and 32 in every framing, with bit 7 forced high.
  task automatic t_slots;
    for (int i = 0; i < 3; i++)
    begin
      fmt = aps_pkg::aps_fmt_t'(i);
      wr(`APS_OFS_CH7, 8'hFF);
      wr(`APS_OFS_CH8, 8'hA0);
      step;
      chk_rd(`APS_OFS_CH7, 8'h7F);
      chk_rd(`APS_OFS_CH8, 8'h20);
      `CHK({c7l, c7r, c7s}, (i == 0) ? 8'hBF : 8'hDF)
      `CHK({c8l, c8r, c8s}, (i == 0) ? 8'h20 : 8'h40)
    end
    fmt = aps_pkg::APS_FMT_TDM;
    $display("test slots done");
  endtask : t_slots

  task automatic t_master;
    for (int c = 0; c < 8; c++)
    begin
      wr(`APS_OFS_MCFG, 8'h80 | 8'(c) | ((c % 2) ? 8'h08 : 8'h00));
      step;
      `CHK(ref_khz, ref_tab[c])
      `CHK({ref_ok, ref_fs, master}, 3'h5)
      `CHK(base_hz, (c % 2) ? 17'h0AC44 : 17'h0BB80)
    end
    refsel = 1'b1;
    step;
    `CHK({ref_ok, ref_fs, ref_khz}, 18'h10000)
    wr(`APS_OFS_MCFG, 8'h07);
    refsel = 1'b0;
    step;
    `CHK({ref_ok, ref_fs, ref_khz}, 18'h0)
    $display("test master done");
  endtask : t_master

  task automatic t_clock;
    gen_b = 1'b1;
    gen_f = 1'b1;
    wr(`APS_OFS_MCFG, 8'h80);
    step;
    `CHK({boe, foe, bo, fo, bl, fl}, 6'h3F)
    wr(`APS_OFS_MCFG, 8'h90);
    step;
    `CHK({boe, foe, bo, fo}, 4'hC)
    wr(`APS_OFS_MCFG, 8'h10);
    step;
    prev = bl;
    `CHK({boe, foe, bo, fo}, 4'h0)
    step;
    `CHK(bl, ~prev)
    wr(`APS_OFS_MCFG, 8'hC0);
    step;
    `CHK({auto_en, pll_en}, 2'h0)
    wr(`APS_OFS_MCFG, 8'h20);
    step;
    `CHK({auto_en, pll_en}, 2'h2)
    $display("test clock done");
  endtask : t_clock

  // Main sequence after eight cycles of reset.
  initial
  begin
    {srst, we, refsel, gen_b, gen_f, addr, wdata} = {1'b1, 20'h0};
    fmt = aps_pkg::APS_FMT_TDM;
    repeat (8) step;
    srst = 1'b0;
    step;
    step;
    t_reset;
    t_slots;
    t_master;
    t_clock;
    give_verdict;
  end

  // A hang is cut short well past the eighty or so cycles the tests need.
  initial
  begin
    #50000;
    miscompares++;
    give_verdict;
  end
endmodule : aps_slot_clk_cfg_tb
